// ===== hdl/djk_pkg.sv
package djk_pkg;

  // Number of storage elements in the block.
  localparam int unsigned DJK_NUM_ELEM = 2;

  // Values the outputs take while rst_i is high.
  localparam logic DJK_Q_RST   = 1'b0;
  localparam logic DJK_Q_N_RST = 1'b1;

  // Level a sampled shared clock is assumed to have before the first sample.
  localparam logic DJK_CLK_RST = 1'b0;

  // Local clock period and the data setup time ahead of the falling edge.
  localparam int unsigned DJK_CLK_PERIOD_PS = 5000;
  localparam int unsigned DJK_SETUP_PS      = 5000;

  // Setup time as whole clock cycles, rounded up, at least one.
  localparam int unsigned DJK_SETUP_RAW =
    (DJK_SETUP_PS + DJK_CLK_PERIOD_PS - 1) / DJK_CLK_PERIOD_PS;
  localparam int unsigned DJK_SETUP_CYC = (DJK_SETUP_RAW < 1) ? 1 : DJK_SETUP_RAW;

endpackage

// ===== hdl/djk_dual_jk.sv
`timescale 1ns/1ps
module djk_dual_jk #(
  parameter int unsigned SETUP_CYC = djk_pkg::DJK_SETUP_CYC
) (
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic                            shared_clock_in_i,
  input  wire logic [djk_pkg::DJK_NUM_ELEM-1:0] j_i,
  input  wire logic [djk_pkg::DJK_NUM_ELEM-1:0] k_i,
  input  wire logic [djk_pkg::DJK_NUM_ELEM-1:0] set_n_i,
  input  wire logic                            clr_n_i,
  output logic      [djk_pkg::DJK_NUM_ELEM-1:0] q_o,
  output logic      [djk_pkg::DJK_NUM_ELEM-1:0] q_n_o
);
  import djk_pkg::*;

  logic                    clk_prev_reg;
  logic                    fall_w;
  logic                    rise_w;
  logic [DJK_NUM_ELEM-1:0] j_pipe_reg [SETUP_CYC];
  logic [DJK_NUM_ELEM-1:0] k_pipe_reg [SETUP_CYC];
  logic [DJK_NUM_ELEM-1:0] j_smp;
  logic [DJK_NUM_ELEM-1:0] k_smp;

  // Previous level of the shared clock pin, used to find its edges.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_prev_reg <= DJK_CLK_RST;
    end else begin
      clk_prev_reg <= shared_clock_in_i;
    end
  end

  assign fall_w = clk_prev_reg & ~shared_clock_in_i;
  assign rise_w = ~clk_prev_reg & shared_clock_in_i;

  // Data inputs delayed by the setup time so the edge sees earlier levels.
  always_ff @(posedge clk_i) begin
    j_pipe_reg[0] <= j_i;
    k_pipe_reg[0] <= k_i;
    for (int unsigned s = 1; s < SETUP_CYC; s++) begin
      j_pipe_reg[s] <= j_pipe_reg[s-1];
      k_pipe_reg[s] <= k_pipe_reg[s-1];
    end
  end

  assign j_smp = j_pipe_reg[SETUP_CYC-1];
  assign k_smp = k_pipe_reg[SETUP_CYC-1];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // One storage element per index, each with its own set and the shared clear.
  for (genvar e = 0; e < DJK_NUM_ELEM; e++) begin : g_elem
    logic forced_w;

    assign forced_w = ~set_n_i[e] | ~clr_n_i;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        q_o[e]   <= DJK_Q_RST;
        q_n_o[e] <= DJK_Q_N_RST;
      end else if (forced_w) begin
        q_o[e]   <= ~set_n_i[e];
        q_n_o[e] <= ~clr_n_i;
      end else if (fall_w) begin
        case ({j_smp[e], k_smp[e]})
          2'h3: begin
            q_o[e]   <= q_n_o[e];
            q_n_o[e] <= q_o[e];
          end
          2'h2: begin
            q_o[e]   <= 1'b1;
            q_n_o[e] <= 1'b0;
          end
          2'h1: begin
            q_o[e]   <= 1'b0;
            q_n_o[e] <= 1'b1;
          end
          default: begin
            q_o[e]   <= q_o[e];
            q_n_o[e] <= q_n_o[e];
          end
        endcase
      end
    end

    set_force_a: assert property (
      !set_n_i[e] |=> q_o[e])
      else $error("Set low did not force the true output high.");

    clr_force_a: assert property (
      (!clr_n_i && set_n_i[e]) |=> (q_n_o[e] && !q_o[e]))
      else $error("Clear low did not force the complement output high.");

    clr_any_a: assert property (
      !clr_n_i |=> q_n_o[e])
      else $error("Clear low left the complement output low.");

    set_block_a: assert property (
      (!set_n_i[e] && clr_n_i && fall_w) |=> (q_o[e] && !q_n_o[e]))
      else $error("A falling edge was taken while set was low.");

    clr_block_a: assert property (
      (!clr_n_i && set_n_i[e] && fall_w) |=> (!q_o[e] && q_n_o[e]))
      else $error("A falling edge was taken while clear was low.");

    data_pipe_a: assert property (
      (j_smp[e] == $past(j_i[e], SETUP_CYC)) && (k_smp[e] == $past(k_i[e], SETUP_CYC)))
      else $error("Data used at the edge was not the earlier level.");

    both_low_a: assert property (
      (!set_n_i[e] && !clr_n_i) |=> (q_o[e] && q_n_o[e]))
      else $error("Set and clear low did not drive both outputs high.");

    async_act_a: assert property (
      (!set_n_i[e] && clr_n_i && !fall_w) |=> (q_o[e] && !q_n_o[e]))
      else $error("Set did not act away from a clock edge.");

    toggle_edge_a: assert property (
      (fall_w && set_n_i[e] && clr_n_i && j_smp[e] && k_smp[e])
        |=> (q_o[e] == $past(q_n_o[e])) && (q_n_o[e] == $past(q_o[e])))
      else $error("Both data inputs high did not swap the outputs.");

    jk_set_a: assert property (
      (fall_w && set_n_i[e] && clr_n_i && j_smp[e] && !k_smp[e]) |=> (q_o[e] && !q_n_o[e]))
      else $error("First data input high did not set the element.");

    jk_clr_a: assert property (
      (fall_w && set_n_i[e] && clr_n_i && !j_smp[e] && k_smp[e]) |=> (!q_o[e] && q_n_o[e]))
      else $error("Second data input high did not clear the element.");

    jk_hold_a: assert property (
      (fall_w && set_n_i[e] && clr_n_i && !j_smp[e] && !k_smp[e])
        |=> ($stable(q_o[e]) && $stable(q_n_o[e])))
      else $error("Both data inputs low did not hold the element.");

    no_edge_hold_a: assert property (
      (!fall_w && set_n_i[e] && clr_n_i) |=> ($stable(q_o[e]) && $stable(q_n_o[e])))
      else $error("State changed without a falling clock edge.");

    rise_hold_a: assert property (
      (rise_w && set_n_i[e] && clr_n_i) |=> ($stable(q_o[e]) && $stable(q_n_o[e])))
      else $error("State changed on a rising clock edge.");

    release_keep_a: assert property (
      (!set_n_i[e] && !clr_n_i) ##1 (set_n_i[e] && clr_n_i && !fall_w)[*2]
        |=> (q_o[e] && q_n_o[e]))
      else $error("Forced value was lost before a falling clock edge.");

    toggle_seen_c: cover property (
      fall_w && set_n_i[e] && clr_n_i && j_smp[e] && k_smp[e]);

    both_forced_c: cover property (!set_n_i[e] && !clr_n_i);

    release_edge_c: cover property (
      !set_n_i[e] ##1 (set_n_i[e] && clr_n_i)[*2] ##1 fall_w);
  end

  set_other_a: assert property (
    (!set_n_i[1] && set_n_i[0] && clr_n_i && !fall_w) |=> $stable(q_o[0]))
    else $error("Set of the second element disturbed the first.");

  fall_find_a: assert property (
    !$past(rst_i) |-> (fall_w == ($past(shared_clock_in_i) && !shared_clock_in_i)))
    else $error("Falling edge of the shared clock was not found.");

  rst_value_a: assert property (
    disable iff (1'b0)
    rst_i |=> (q_o == {DJK_NUM_ELEM{DJK_Q_RST}}) && (q_n_o == {DJK_NUM_ELEM{DJK_Q_N_RST}}))
    else $error("Reset did not give the reset output values.");

  set_fall_c: cover property (!set_n_i[0] && clr_n_i && fall_w);

  rise_seen_c: cover property (rise_w && set_n_i[0] && clr_n_i);

  set_local_a: assert property (
    (!set_n_i[0] && set_n_i[1] && clr_n_i && !fall_w) |=> $stable(q_o[1]))
    else $error("Set of one element disturbed the other.");

  clr_shared_a: assert property (
    (!clr_n_i && set_n_i[0] && set_n_i[1]) |=> (q_o == '0) && (q_n_o == '1))
    else $error("Shared clear did not clear both elements.");

endmodule

// ===== dv/djk_src.sv
`timescale 1ns/1ps
module djk_src (
  input  wire logic       clk_i,
  output logic            pin_o,
  output logic [1:0]      j_o,
  output logic [1:0]      k_o,
  output logic [1:0]      set_n_o,
  output logic            clr_n_o
);
  initial begin
    pin_o = 1'b0;
    j_o = 2'h0;
    k_o = 2'h0;
    set_n_o = 2'h3;
    clr_n_o = 1'b1;
  end
  // Called just after a rising clk_i edge; levels hold until the next call.
  task automatic drive(input logic p, input logic [1:0] j, k, s, input logic c);
    pin_o <= p;
    j_o <= j;
    k_o <= k;
    set_n_o <= s;
    clr_n_o <= c;
  endtask
endmodule

// ===== dv/djk_dual_jk_bench.sv
`timescale 1ns/1ps
module djk_dual_jk_bench;
  import djk_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       pin, c_n, pp;
  logic [1:0] j, k, s_n, q, q_n, jp, kp, mq, mqn;
  logic [3:0] e4;
  logic [3:0] exp_q[$];
  int         err_total = 0;
  int         num_checks = 0;
  initial forever #2.5 clk_i = ~clk_i;
  djk_src src (.clk_i(clk_i), .pin_o(pin), .j_o(j), .k_o(k), .set_n_o(s_n), .clr_n_o(c_n));
  djk_dual_jk dut (.clk_i(clk_i), .rst_i(rst_i), .shared_clock_in_i(pin), .j_i(j), .k_i(k),
                   .set_n_i(s_n), .clr_n_i(c_n), .q_o(q), .q_n_o(q_n));
  task automatic check(input string nm, input logic [1:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Notes the outputs expected after this edge, then drives the next levels.
  task automatic step(input logic r, p, input logic [1:0] nj, nk, ns, input logic nc);
    @(posedge clk_i);
    for (int e = 0; e < 2; e++) begin
      if (rst_i) begin
        mq[e] = DJK_Q_RST;
        mqn[e] = DJK_Q_N_RST;
      end else if (!s_n[e] || !c_n) begin
        mq[e] = !s_n[e];
        mqn[e] = !c_n;
      end else if (pp && !pin) begin
        case ({jp[e], kp[e]})
          2'h3: {mq[e], mqn[e]} = {mqn[e], mq[e]};
          2'h2: {mq[e], mqn[e]} = 2'h2;
          2'h1: {mq[e], mqn[e]} = 2'h1;
          default: ;
        endcase
      end
    end
    pp = rst_i ? DJK_CLK_RST : pin;
    jp = j;
    kp = k;
    exp_q.push_back({mq, mqn});
    rst_i <= r;
    src.drive(p, nj, nk, ns, nc);
  endtask
  always @(negedge clk_i) begin
    if (exp_q.size() > 0) begin
      e4 = exp_q.pop_front();
      check("q_o", q, e4[3:2]);
      check("q_n_o", q_n, e4[1:0]);
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(52));
    repeat (10) step(1'b1, 1'b0, 2'h0, 2'h0, 2'h3, 1'b1);
    repeat (2) step(1'b0, 1'b0, 2'h0, 2'h0, 2'h3, 1'b1);
    for (int c = 0; c < 16; c++) begin
      step(1'b0, 1'b1, 2'(c), 2'(c >> 2), 2'h3, 1'b1);
      step(1'b0, 1'b0, ~2'(c), ~2'(c >> 2), 2'h3, 1'b1);
    end
    $display("test directed done");
    repeat (3000) step(($urandom % 64) == 0, 1'($urandom), 2'($urandom), 2'($urandom),
                       {|3'($urandom), |3'($urandom)}, |3'($urandom));
    step(1'b0, 1'b0, 2'h0, 2'h0, 2'h3, 1'b1);
    repeat (2) @(negedge clk_i);
    $display("test random done");
    tally_and_finish();
  end
endmodule
